//--- rtl/gpp_pkg.sv
// Shared constants and types for the five-pin general purpose port.
package gpp_pkg;

   // Clock and timing figures.
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned PWM_HZ          = 100;
   localparam int unsigned PWM_STEPS       = 100;
   localparam int unsigned SAMPLE_HZ       = 32;
   localparam int unsigned PWM_STEP_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
   localparam int unsigned SAMPLE_CYCLES   = CLK_HZ / SAMPLE_HZ;

   // Command codes and reply types.
   localparam logic [7:0] CMD_SET_PIN  = 8'h22;
   localparam logic [7:0] CMD_READ_PIN = 8'h23;
   localparam logic [7:0] RSP_ACK_BIT  = 8'h40;
   localparam logic [7:0] RSP_ERR_BITS = 8'hC0;
   localparam logic [7:0] LEN_SET_VAL  = 8'h02;
   localparam logic [7:0] LEN_SET_CFG  = 8'h03;
   localparam logic [7:0] LEN_READ     = 8'h01;
   localparam logic [7:0] LEN_READ_RSP = 8'h04;
   localparam logic [7:0] LEN_NONE     = 8'h00;

   // Output state values.
   localparam logic [6:0] DUTY_LOW  = 7'h00;
   localparam logic [6:0] DUTY_HIGH = 7'h64;

   // Configuration byte layout.
   localparam int unsigned CFG_FUNC_BIT = 3;
   localparam logic [3:0]  CFG_RSV_MASK = 4'hF;

   // Status byte layout.
   localparam int unsigned ST_LEVEL_BIT = 0;
   localparam int unsigned ST_FALL_BIT  = 1;
   localparam int unsigned ST_RISE_BIT  = 2;

   // Reset configuration per pin, pin 4 in the top nibble.
   localparam logic [19:0] PIN_RST_CFG = 20'h2_2232;

   // Drive modes of the configuration byte.
   typedef enum logic [2:0] {
      DM_UP_FAST_PD   = 3'b000,
      DM_PUSH_FAST    = 3'b001,
      DM_HIZ          = 3'b010,
      DM_PU_DN_FAST   = 3'b011,
      DM_UP_SLOW_HIZ  = 3'b100,
      DM_PUSH_SLOW    = 3'b101,
      DM_RESERVED     = 3'b110,
      DM_HIZ_DN_SLOW  = 3'b111
   } gpp_drive_mode_t;

endpackage

//--- rtl/gpp_pin.sv
// One port pin: stored request, drive control and the sampled level with edge flags.
`timescale 1ns/100ps
module gpp_pin
   import gpp_pkg::*;
#(
   parameter logic [3:0] RST_CFG = 4'h2
) (
   input  wire logic       clk_i,        // Core clock.
   input  wire logic       arst_n_i,     // Asynchronous reset, active low.
   input  wire logic       sample_i,     // Sampling strobe, one cycle.
   input  wire logic [6:0] pwm_phase_i,  // PWM phase, 0 to 99.
   input  wire logic       wr_val_i,     // Store a new output state.
   input  wire logic       wr_cfg_i,     // Store a new configuration.
   input  wire logic [6:0] val_i,        // Output state to store.
   input  wire logic [3:0] cfg_i,        // Configuration to store.
   input  wire logic       clr_i,        // Restart the edge flags.
   input  wire logic       pin_i,        // Pin level.
   input  wire logic       dflt_o_i,     // Default function drive level.
   input  wire logic       dflt_oe_n_i,  // Default function enable, active low.
   output logic            level_o,      // Last sampled level.
   output logic            rise_o,       // Rising edge seen.
   output logic            fall_o,       // Falling edge seen.
   output logic [6:0]      duty_o,       // Stored output state.
   output logic [3:0]      cfg_o,        // Stored configuration.
   output logic            pin_o,        // Pin drive level.
   output logic            pin_oe_n_o,   // Pin drive enable, active low.
   output logic            pull_up_o,    // Resistive pull-up on.
   output logic            pull_dn_o,    // Resistive pull-down on.
   output logic            slow_o        // Slow edge rate.
);

   typedef struct packed {
      logic [6:0] duty;
      logic [3:0] cfg;
      logic       primed;
      logic       level;
      logic       rise;
      logic       fall;
      logic       drv;
      logic       oe_n;
      logic       pu;
      logic       pd;
      logic       slow;
   } gpp_pin_state_t;

   gpp_pin_state_t st;
   gpp_pin_state_t next_st;
   logic           req;
   logic           rise_ev;
   logic           fall_ev;

   // Request level, sampled edges and the drive decode.
   always_comb begin
      next_st = st;
      req     = (st.duty == DUTY_HIGH) || (st.duty != DUTY_LOW && pwm_phase_i < st.duty);
      if (wr_val_i) begin
         next_st.duty = val_i;
      end
      if (wr_cfg_i) begin
         next_st.cfg = cfg_i;
      end
      // Edges come only from two consecutive samples, so short pulses vanish.
      rise_ev = sample_i && st.primed && !st.level && pin_i;
      fall_ev = sample_i && st.primed && st.level && !pin_i;
      if (sample_i) begin
         next_st.level  = pin_i;
         next_st.primed = 1'b1;
      end
      // A new edge in the query cycle wins over the restart.
      next_st.rise = (st.rise && !clr_i) || rise_ev;
      next_st.fall = (st.fall && !clr_i) || fall_ev;
      next_st.drv  = req;
      next_st.oe_n = 1'b1;
      next_st.pu   = 1'b0;
      next_st.pd   = 1'b0;
      next_st.slow = 1'b0;
      if (!st.cfg[CFG_FUNC_BIT]) begin
         // Default role keeps its own drive; pulls stay off.
         next_st.drv  = dflt_o_i;
         next_st.oe_n = dflt_oe_n_i;
      end else begin
         case (gpp_drive_mode_t'(st.cfg[2:0]))
            DM_UP_FAST_PD: begin
               next_st.oe_n = !req;
               next_st.pd   = !req;
            end
            DM_PUSH_FAST: begin
               next_st.oe_n = 1'b0;
            end
            DM_PU_DN_FAST: begin
               next_st.oe_n = req;
               next_st.pu   = req;
            end
            DM_UP_SLOW_HIZ: begin
               next_st.oe_n = !req;
               next_st.slow = 1'b1;
            end
            DM_PUSH_SLOW: begin
               next_st.oe_n = 1'b0;
               next_st.slow = 1'b1;
            end
            DM_HIZ_DN_SLOW: begin
               next_st.oe_n = req;
               next_st.slow = 1'b1;
            end
            default: begin
               next_st.oe_n = 1'b1;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st     <= '0;
         st.cfg <= RST_CFG;
         st.oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign level_o    = st.level;
   assign rise_o     = st.rise;
   assign fall_o     = st.fall;
   assign duty_o     = st.duty;
   assign cfg_o      = st.cfg;
   assign pin_o      = st.drv;
   assign pin_oe_n_o = st.oe_n;
   assign pull_up_o  = st.pu;
   assign pull_dn_o  = st.pd;
   assign slow_o     = st.slow;

endmodule

//--- rtl/gpp_port.sv
// Five-pin general purpose port with PWM outputs, sampled inputs and command replies.
//
// Behaviour
// - Five pins at indices 0 to 4; indices 5 and up select nothing.
// - State 0 low, 1 to 99 PWM duty at 100Hz, 100 high, above invalid.
// - Set command: two bytes change value only, three also set function and drive.
// - Modes 000, 001, 010, 011: fast drive, pulls and high-impedance as coded.
// - Modes 100, 101, 111 slow drive variants; 110 reserved, never driven.
// - Function 0 gives pin its default role; 1 puts it under user control.
// - Every pin sampled at 32Hz regardless of queries, giving bounce-free readings.
// - Rising and falling edges latched per pin since last query, restarted by it.
// - Status byte: level bit 0, falling bit 1, rising bit 2, others zero.
// - Reported level is the sampled pin, not the requested output.
// - Changes starting and ending between two samples produce no indication.
// - Read command: one index byte; reply index, status, duty, configuration.
// - Reported request is the stored duty value 0 to 100.
// - Reserved upper configuration bits read as zero.
// - Pins 1 to 3 default to power sense and control, pin 4 one-wire.
`timescale 1ns/100ps
module gpp_port
   import gpp_pkg::*;
#(
   parameter int unsigned NUM_PINS    = 5,
   parameter int unsigned SAMPLE_DIV  = SAMPLE_CYCLES,
   parameter int unsigned PWM_STEP_DV = PWM_STEP_CYCLES
) (
   input  wire logic                clk_i,        // Core clock, 25 MHz.
   input  wire logic                arst_n_i,     // Asynchronous reset, active low.
   input  wire logic                cmd_valid_i,  // Command packet present, one cycle.
   input  wire logic [7:0]          cmd_code_i,   // Command code.
   input  wire logic [7:0]          cmd_len_i,    // Data length of the command.
   input  wire logic [7:0]          cmd_d0_i,     // Data byte 0, pin index.
   input  wire logic [7:0]          cmd_d1_i,     // Data byte 1, output state.
   input  wire logic [7:0]          cmd_d2_i,     // Data byte 2, configuration.
   output logic                     rsp_valid_o,  // Reply present, one cycle.
   output logic [7:0]               rsp_type_o,   // Reply type.
   output logic [7:0]               rsp_len_o,    // Reply data length.
   output logic [7:0]               rsp_d0_o,     // Reply byte 0.
   output logic [7:0]               rsp_d1_o,     // Reply byte 1.
   output logic [7:0]               rsp_d2_o,     // Reply byte 2.
   output logic [7:0]               rsp_d3_o,     // Reply byte 3.
   input  wire logic [NUM_PINS-1:0] pin_i,        // Pin levels.
   input  wire logic [NUM_PINS-1:0] dflt_o_i,     // Default function drive levels.
   input  wire logic [NUM_PINS-1:0] dflt_oe_n_i,  // Default function enables, active low.
   output logic [NUM_PINS-1:0]      pin_o,        // Pin drive levels.
   output logic [NUM_PINS-1:0]      pin_oe_n_o,   // Pin drive enables, active low.
   output logic [NUM_PINS-1:0]      pull_up_o,    // Pull-up enables.
   output logic [NUM_PINS-1:0]      pull_dn_o,    // Pull-down enables.
   output logic [NUM_PINS-1:0]      slow_o        // Slow edge enables.
);

   // The index byte is eight bits wide and the reset table holds five pins.
   if (NUM_PINS < 1 || NUM_PINS > 5 || SAMPLE_DIV < 2 || SAMPLE_DIV > 2**24 || PWM_STEP_DV < 1
       || PWM_STEP_DV > 2**16) begin : g_bad_param
      $error("gpp_port parameters out of range");
   end

   // All timer, strobe and reply state of the port sits in one registered word.
   // The reply length and data bytes fall back to zero between replies, so a stale status never leaks; the reply type holds.
   typedef struct packed {
      logic [15:0] step_cnt;
      logic [6:0]  phase;
      logic [23:0] smp_cnt;
      logic        smp;
      logic        rsp_valid;
      logic [7:0]  rsp_type;
      logic [7:0]  rsp_len;
      logic [7:0]  d0;
      logic [7:0]  d1;
      logic [7:0]  d2;
      logic [7:0]  d3;
   } gpp_port_state_t;

   // Terminal counts, cut to the width of the counters that compare against them.
   localparam logic [15:0] STEP_LAST  = 16'(PWM_STEP_DV - 1);
   localparam logic [6:0]  PHASE_LAST = 7'(PWM_STEPS - 1);
   localparam logic [23:0] SMP_LAST   = 24'(SAMPLE_DIV - 1);
   localparam logic [7:0]  PIN_COUNT  = 8'(NUM_PINS);

   // Per-pin write and clear strobes, and the stored view of every pin cell.
   gpp_port_state_t     st;
   gpp_port_state_t     next_st;
   logic [NUM_PINS-1:0] wr_val;
   logic [NUM_PINS-1:0] wr_cfg;
   logic [NUM_PINS-1:0] clr;
   logic [NUM_PINS-1:0] lvl;
   logic [NUM_PINS-1:0] rise;
   logic [NUM_PINS-1:0] fall;
   logic [6:0]          duty [NUM_PINS];
   logic [3:0]          cfg  [NUM_PINS];
   logic                idx_ok;
   logic                set_ok;
   logic                is_set;
   logic                is_read;
   logic [2:0]          sel;

   // Command decode, timers and reply build.
   always_comb begin
      next_st = st;
      wr_val  = '0;
      wr_cfg  = '0;
      clr     = '0;
      sel     = cmd_d0_i[2:0];
      idx_ok  = cmd_d0_i < PIN_COUNT;
      is_set  = cmd_valid_i && cmd_code_i == CMD_SET_PIN;
      is_read = cmd_valid_i && cmd_code_i == CMD_READ_PIN;
      // Out-of-range states, reserved bits and the reserved mode are refused.
      set_ok  = idx_ok && cmd_d1_i <= {1'b0, DUTY_HIGH}
                && (cmd_len_i == LEN_SET_VAL
                    || (cmd_len_i == LEN_SET_CFG && (cmd_d2_i[7:4] & CFG_RSV_MASK) == 4'h0
                        && cmd_d2_i[2:0] != DM_RESERVED));
      // Free-running PWM phase, 100 steps a period.
      if (st.step_cnt == STEP_LAST) begin
         next_st.step_cnt = '0;
         next_st.phase    = (st.phase == PHASE_LAST) ? 7'h00 : st.phase + 7'h01;
      end else begin
         next_st.step_cnt = st.step_cnt + 16'h0001;
      end
      // Sampling strobe, independent of any command.
      next_st.smp = st.smp_cnt == SMP_LAST;
      next_st.smp_cnt = next_st.smp ? 24'h00_0000 : st.smp_cnt + 24'h00_0001;
      next_st.rsp_valid = 1'b0;
      next_st.rsp_len   = LEN_NONE;
      next_st.d0 = 8'h00;
      next_st.d1 = 8'h00;
      next_st.d2 = 8'h00;
      next_st.d3 = 8'h00;
      // A set or a read always answers one cycle later, refused or not; other codes stay silent.
      // A refused set stores nothing, so a half-valid packet never changes a pin.
      if (is_set) begin
         next_st.rsp_valid = 1'b1;
         next_st.rsp_type  = (set_ok ? RSP_ACK_BIT : RSP_ERR_BITS) | cmd_code_i;
         for (int i = 0; i < NUM_PINS; i++) begin
            if (set_ok && sel == 3'(i)) begin
               wr_val[i] = 1'b1;
               wr_cfg[i] = cmd_len_i == LEN_SET_CFG;
            end
         end
      end else if (is_read) begin
         next_st.rsp_valid = 1'b1;
         if (idx_ok && cmd_len_i == LEN_READ) begin
            next_st.rsp_type = RSP_ACK_BIT | cmd_code_i;
            next_st.rsp_len  = LEN_READ_RSP;
            next_st.d0       = cmd_d0_i;
            // The query restarts the edge flags of the pin that it reports, and only that pin.
            for (int i = 0; i < NUM_PINS; i++) begin
               if (sel == 3'(i)) begin
                  clr[i] = 1'b1;
                  next_st.d1[ST_LEVEL_BIT] = lvl[i];
                  next_st.d1[ST_FALL_BIT]  = fall[i];
                  next_st.d1[ST_RISE_BIT]  = rise[i];
                  next_st.d2 = {1'b0, duty[i]};
                  next_st.d3 = {4'h0, cfg[i]};
               end
            end
         end else begin
            next_st.rsp_type = RSP_ERR_BITS | cmd_code_i;
         end
      end
   end

   // State register.
   // Reset clears the timers, so the first sampling strobe comes a full period after release.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // One cell per pin, each with its own default role configuration.
   // Each cell registers its own pin controls, so every pin output leaves a flip-flop.
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      gpp_pin #(
         .RST_CFG (PIN_RST_CFG[4*g +: 4])
      ) u_pin (
         .clk_i       (clk_i),
         .arst_n_i    (arst_n_i),
         .sample_i    (st.smp),
         .pwm_phase_i (st.phase),
         .wr_val_i    (wr_val[g]),
         .wr_cfg_i    (wr_cfg[g]),
         .val_i       (cmd_d1_i[6:0]),
         .cfg_i       (cmd_d2_i[3:0]),
         .clr_i       (clr[g]),
         .pin_i       (pin_i[g]),
         .dflt_o_i    (dflt_o_i[g]),
         .dflt_oe_n_i (dflt_oe_n_i[g]),
         .level_o     (lvl[g]),
         .rise_o      (rise[g]),
         .fall_o      (fall[g]),
         .duty_o      (duty[g]),
         .cfg_o       (cfg[g]),
         .pin_o       (pin_o[g]),
         .pin_oe_n_o  (pin_oe_n_o[g]),
         .pull_up_o   (pull_up_o[g]),
         .pull_dn_o   (pull_dn_o[g]),
         .slow_o      (slow_o[g])
      );
   end

   assign rsp_valid_o = st.rsp_valid;
   assign rsp_type_o  = st.rsp_type;
   assign rsp_len_o   = st.rsp_len;
   assign rsp_d0_o    = st.d0;
   assign rsp_d1_o    = st.d1;
   assign rsp_d2_o    = st.d2;
   assign rsp_d3_o    = st.d3;

endmodule

//--- tb/gpp_port_properties.sv
// Concurrent checks on the command and reply ports of the pin port.
`timescale 1ns/100ps
module gpp_port_properties
   import gpp_pkg::*;
(
   input wire logic       clk_i,        // Clock.
   input wire logic       arst_n_i,     // Reset, active low.
   input wire logic       cmd_valid_i,  // Command strobe.
   input wire logic [7:0] cmd_code_i,   // Code.
   input wire logic [7:0] cmd_len_i,    // Length.
   input wire logic [7:0] cmd_d0_i,     // Index.
   input wire logic [7:0] cmd_d1_i,     // State.
   input wire logic       rsp_valid_o,  // Reply strobe.
   input wire logic [7:0] rsp_type_o,   // Reply type.
   input wire logic [7:0] rsp_len_o,    // Reply length.
   input wire logic [7:0] rsp_d0_o,     // Index.
   input wire logic [7:0] rsp_d1_o,     // Status.
   input wire logic [7:0] rsp_d2_o,     // Duty.
   input wire logic [7:0] rsp_d3_o      // Configuration.
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   logic known;
   logic set_cmd;
   logic set_ok;
   logic rd_ok;
   logic rpt;
   // Decodes of the set and read codes, of well-formed two-byte sets and reads, and of a full read reply.
   assign known = cmd_valid_i && cmd_code_i inside {CMD_SET_PIN, CMD_READ_PIN};
   assign set_cmd = cmd_valid_i && cmd_code_i == CMD_SET_PIN;
   assign set_ok = set_cmd && cmd_len_i == LEN_SET_VAL && cmd_d0_i < 8'h05 && cmd_d1_i <= 8'h64;
   assign rd_ok = cmd_valid_i && cmd_code_i == CMD_READ_PIN && cmd_len_i == LEN_READ && cmd_d0_i < 8'h05;
   assign rpt = rsp_valid_o && rsp_len_o == LEN_READ_RSP;
   rsp_follows_a: assert property (known |=> rsp_valid_o)
      else $error("reply missing");
   other_silent_a: assert property (!known |=> !rsp_valid_o)
      else $error("unexpected reply");
   set_ack_a: assert property (set_ok |=> rsp_type_o == (CMD_SET_PIN | RSP_ACK_BIT) && rsp_len_o == LEN_NONE)
      else $error("bad set acknowledge");
   idx_refuse_a: assert property (set_cmd && cmd_d0_i > 8'h04 |=> rsp_type_o == (CMD_SET_PIN | RSP_ERR_BITS))
      else $error("index not refused");
   state_refuse_a: assert property (set_cmd && cmd_d1_i > 8'h64 |=> rsp_type_o == (CMD_SET_PIN | RSP_ERR_BITS))
      else $error("state not refused");
   rd_echo_a: assert property (rd_ok |=> rpt && rsp_d0_o == $past(cmd_d0_i))
      else $error("read reply wrong");
   status_rsv_a: assert property (rpt |-> rsp_d1_o[7:3] == 5'h00)
      else $error("status upper bits set");
   cfg_rsv_a: assert property (rpt |-> rsp_d3_o[7:4] == 4'h0)
      else $error("config upper bits set");
   duty_range_a: assert property (rpt |-> rsp_d2_o <= 8'h64)
      else $error("duty out of range");
   refuse_len_a: assert property (rsp_valid_o && rsp_type_o[7] |-> rsp_len_o == LEN_NONE)
      else $error("refusal carries data");
   cover property (set_ok);
   cover property (rd_ok);
   cover property (rpt && rsp_d1_o[2:1] == 2'b11);
endmodule
bind gpp_port gpp_port_properties u_props (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
   .cmd_len_i(cmd_len_i), .cmd_d0_i(cmd_d0_i), .cmd_d1_i(cmd_d1_i), .rsp_valid_o(rsp_valid_o),
   .rsp_type_o(rsp_type_o), .rsp_len_o(rsp_len_o), .rsp_d0_o(rsp_d0_o), .rsp_d1_o(rsp_d1_o),
   .rsp_d2_o(rsp_d2_o), .rsp_d3_o(rsp_d3_o));

//--- tb/gpp_pin_load.sv
// External load on the port pins: a bench driver, the pulls and a released line.
`timescale 1ns/100ps
module gpp_pin_load (
   input  wire logic [4:0] pin_o,       // Port drive level.
   input  wire logic [4:0] pin_oe_n_o,  // Port drive enable, active low.
   input  wire logic [4:0] pull_up_o,   // Pull-up enables.
   input  wire logic [4:0] pull_dn_o,   // Pull-down enables.
   input  wire logic [4:0] ext_en_i,    // External driver on.
   input  wire logic [4:0] ext_val_i,   // External driver level.
   output logic      [4:0] pin_i        // Resolved pin level.
);
   // A stiff external driver wins over the port, then drive, then pulls.
   // The one-wire line has its own board pull-up; a line nobody holds shows the opposite of the
   // port's drive level, so a stale value never passes for a driven one.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (ext_en_i[i]) pin_i[i] = ext_val_i[i];
         else if (!pin_oe_n_o[i]) pin_i[i] = pin_o[i];
         else if (pull_up_o[i] || i == 4) pin_i[i] = 1'b1;
         else if (pull_dn_o[i]) pin_i[i] = 1'b0;
         else pin_i[i] = !pin_o[i];
      end
   end
endmodule

//--- tb/test_gpp_port.sv
// Self-checking bench for the five-pin port: replies, drive modes, PWM and sampled edges.
`timescale 1ns/100ps
module test_gpp_port;
   import gpp_pkg::*;
   localparam int unsigned SDIV = 8;
   localparam int unsigned PDIV = 2;
   logic       clk_i = 1'b0, arst_n_i = 1'b0, cmd_valid_i = 1'b0, rsp_valid_o;
   logic [7:0] cmd_code_i = 8'h00, cmd_len_i = 8'h00, cmd_d0_i = 8'h00, cmd_d1_i = 8'h00, cmd_d2_i = 8'h00;
   logic [7:0] rsp_type_o, rsp_len_o, rsp_d0_o, rsp_d1_o, rsp_d2_o, rsp_d3_o;
   logic [4:0] pin_i, pin_o, pin_oe_n_o, pull_up_o, pull_dn_o, slow_o, dflt_o_i = 5'h00, dflt_oe_n_i = 5'h1F;
   logic [4:0] ext_en = 5'h1F, ext_val = 5'h00;
   logic [31:0] seed = 32'h172a_f0fe;
   int err_count = 0, checks_done = 0;
   int duty[5] = '{0, 0, 0, 0, 0}, cfg[5] = '{2, 3, 2, 2, 2};
   int lvl[5] = '{0, 0, 0, 0, 0}, ris[5] = '{0, 0, 0, 0, 0}, fal[5] = '{0, 0, 0, 0, 0};
   int cyc = 0;
   int dl[5] = '{0, 1, 25, 99, 100};
   logic [31:0] bad[6] = '{32'h0205_0000, 32'h0200_6500, 32'h0400_0000, 32'h0300_0019, 32'h0300_000E,
                           32'h0100_0000};
   // Cycles since reset release; samples fall on edges one past a multiple of the sample period.
   always @(posedge clk_i) cyc <= arst_n_i ? cyc + 1 : 0;
   // Free-running 25 MHz clock.
   always #20 clk_i = ~clk_i;
   gpp_port #(.SAMPLE_DIV(SDIV), .PWM_STEP_DV(PDIV)) dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
      .cmd_len_i(cmd_len_i), .cmd_d0_i(cmd_d0_i), .cmd_d1_i(cmd_d1_i), .cmd_d2_i(cmd_d2_i),
      .rsp_valid_o(rsp_valid_o), .rsp_type_o(rsp_type_o), .rsp_len_o(rsp_len_o), .rsp_d0_o(rsp_d0_o),
      .rsp_d1_o(rsp_d1_o), .rsp_d2_o(rsp_d2_o), .rsp_d3_o(rsp_d3_o), .pin_i(pin_i), .dflt_o_i(dflt_o_i),
      .dflt_oe_n_i(dflt_oe_n_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pull_up_o(pull_up_o),
      .pull_dn_o(pull_dn_o), .slow_o(slow_o));
   gpp_pin_load u_load (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pull_up_o(pull_up_o),
      .pull_dn_o(pull_dn_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i(pin_i));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected {enable_n, pull-up, pull-down} per drive mode and requested level.
   function automatic logic [2:0] drv(input int m, input bit r);
      case (m)
         0: return r ? 3'b000 : 3'b101;
         1, 5: return 3'b000;
         3: return r ? 3'b110 : 3'b000;
         4: return r ? 3'b000 : 3'b100;
         7: return r ? 3'b100 : 3'b000;
         default: return 3'b100;
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One command pulse; the reply is looked at in the cycle after it is taken.
   task automatic cmd(input logic [7:0] c, l, a, b, d);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_code_i <= c;
      cmd_len_i <= l;
      cmd_d0_i <= a;
      cmd_d1_i <= b;
      cmd_d2_i <= d;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      #1;
   endtask
   task automatic set(input int p, v, c, l);
      cmd(CMD_SET_PIN, 8'(l), 8'(p), 8'(v), 8'(c));
      chk(rsp_valid_o, 1'b1);
      chk(rsp_type_o, CMD_SET_PIN | RSP_ACK_BIT);
      chk(rsp_len_o, LEN_NONE);
      duty[p] = v;
      if (l == 3) cfg[p] = c;
   endtask
   task automatic rd(input int p);
      cmd(CMD_READ_PIN, LEN_READ, 8'(p), 8'h00, 8'h00);
      chk(rsp_type_o, CMD_READ_PIN | RSP_ACK_BIT);
      chk(rsp_len_o, LEN_READ_RSP);
      chk(rsp_d0_o, 8'(p));
      chk(rsp_d1_o, 8'(ris[p] * 4 + fal[p] * 2 + lvl[p]));
      chk(rsp_d2_o, 8'(duty[p]));
      chk(rsp_d3_o, 8'(cfg[p]));
      ris[p] = 0;
      fal[p] = 0;
   endtask
   // Hold external levels over several samples; lv is the level the pins should show.
   task automatic hold(input logic [4:0] en, v, lv);
      @(posedge clk_i);
      ext_en <= en;
      ext_val <= v;
      for (int i = 0; i < 5; i++) begin
         if (lv[i] && lvl[i] == 0) ris[i] = 1;
         if (!lv[i] && lvl[i] == 1) fal[i] = 1;
         lvl[i] = lv[i];
      end
      repeat (3 * SDIV) @(posedge clk_i);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence.
   initial begin
      int n, p, v, c;
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2 * SDIV) @(posedge clk_i);
      for (int i = 0; i < 5; i++) rd(i);
      $display("test reset done");
      @(posedge clk_i);
      dflt_o_i <= 5'h04;
      dflt_oe_n_i <= 5'h1B;
      repeat (3) @(posedge clk_i);
      #1;
      chk(pin_o[2], 1'b1);
      chk(pin_oe_n_o[2], 1'b0);
      $display("test default role done");
      for (int m = 0; m < 8; m++) begin
         if (m == 6) continue;
         for (int r = 0; r < 2; r++) begin
            set(0, r * 100, 8 + m, 3);
            repeat (3) @(posedge clk_i);
            #1;
            chk({5'h00, pin_oe_n_o[0], pull_up_o[0], pull_dn_o[0]}, {5'h00, drv(m, r[0])});
            chk(pin_o[0], r[0]);
            chk(slow_o[0], 8'(m >= 4));
         end
      end
      $display("test drive modes done");
      hold(5'h1F, 5'h08, 5'h08);
      hold(5'h1F, 5'h00, 5'h00);
      rd(3);
      rd(3);
      hold(5'h1F, 5'h08, 5'h08);
      rd(3);
      // A pulse that starts and ends between two samples must leave no trace.
      @(posedge clk_i);
      while (cyc % SDIV != 0) @(posedge clk_i);
      ext_val <= 5'h0C;
      repeat (3) @(posedge clk_i);
      ext_val <= 5'h08;
      repeat (SDIV) @(posedge clk_i);
      rd(2);
      $display("test edges done");
      set(0, 100, 8'h09, 3);
      hold(5'h0E, 5'h08, 5'h19);
      rd(0);
      rd(4);
      set(0, 100, 8'h0A, 3);
      hold(5'h1F, 5'h08, 5'h08);
      rd(0);
      $display("test actual level done");
      foreach (dl[i]) begin
         set(1, dl[i], 8'h09, 3);
         repeat (4) @(posedge clk_i);
         n = 0;
         repeat (100 * PDIV) begin
            @(posedge clk_i);
            #1 n += pin_o[1];
         end
         chk(8'(n), 8'(dl[i] * PDIV));
      end
      $display("test pwm done");
      foreach (bad[i]) begin
         cmd(CMD_SET_PIN, bad[i][31:24], bad[i][23:16], bad[i][15:8], bad[i][7:0]);
         chk(rsp_type_o, CMD_SET_PIN | RSP_ERR_BITS);
         chk(rsp_len_o, LEN_NONE);
      end
      rd(0);
      cmd(CMD_READ_PIN, 8'h01, 8'h05, 8'h00, 8'h00);
      chk(rsp_type_o, CMD_READ_PIN | RSP_ERR_BITS);
      cmd(8'h21, 8'h00, 8'h00, 8'h00, 8'h00);
      chk(rsp_valid_o, 1'b0);
      $display("test refusals done");
      repeat (30) begin
         p = rnd() % 5;
         v = rnd() % 101;
         c = rnd() & 32'h0000_000F;
         if (c[2:0] == 3'b110) c = c ^ 1;
         set(p, v, c, (rnd() & 1) + 2);
         rd(p);
      end
      $display("test random done");
      test_done();
   end
   // Watchdog, well beyond the fifteen hundred or so cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      test_done();
   end
endmodule
